// ### cfg_pkg.sv
/*
 * Constants, encodings and decode helpers for the configuration and
 * code-protection block.
 * Assumes it is compiled before every file that names it.
 */
package cfg_pkg;

   // ****************************************************************
   // Addresses and reset values
   // ****************************************************************
   localparam logic [15:0] CFG_ONE_ADDR   = 16'hfd00;
   localparam logic [7:0]  UNPROG_BYTE    = 8'hff;
   localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;
   localparam logic        UNPROG_BIT     = 1'b1;

   // ****************************************************************
   // Field positions in the first configuration byte
   // ****************************************************************
   localparam int WATCHDOG_FUSE_POS    = 7;
   localparam int PORT_RESET_LEVEL_POS = 5;
   localparam int OSC_SELECT_LSB       = 0;
   localparam int OSC_SELECT_W         = 3;

   // ****************************************************************
   // Oscillator field codes and decoded modes
   // ****************************************************************
   localparam logic [2:0] OSC_CODE_EXT = 3'h7;
   localparam logic [2:0] OSC_CODE_RC  = 3'h3;
   localparam logic [2:0] OSC_CODE_LF  = 3'h2;
   localparam logic [2:0] OSC_CODE_MF  = 3'h1;
   localparam logic [2:0] OSC_CODE_HF  = 3'h0;

   typedef enum logic [2:0] {
      MODE_HF   = 3'h0,
      MODE_MF   = 3'h1,
      MODE_LF   = 3'h2,
      MODE_RC   = 3'h3,
      MODE_EXT  = 3'h4,
      MODE_RSVD = 3'h7
   } osc_mode_type;

   // ****************************************************************
   // Programming targets and load sequence
   // ****************************************************************
   typedef enum logic [1:0] {
      TGT_CODE  = 2'h0,
      TGT_CFG   = 2'h1,
      TGT_PROT1 = 2'h2,
      TGT_PROT2 = 2'h3
   } pgm_target_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b11
   } load_state_type;

   function automatic osc_mode_type osc_decode(input logic [2:0] code);
      osc_mode_type m;
      m = MODE_RSVD;
      unique case (code)
         OSC_CODE_EXT: m = MODE_EXT;
         OSC_CODE_RC:  m = MODE_RC;
         OSC_CODE_LF:  m = MODE_LF;
         OSC_CODE_MF:  m = MODE_MF;
         OSC_CODE_HF:  m = MODE_HF;
         default:      m = MODE_RSVD;
      endcase
      return m;
   endfunction : osc_decode

endpackage : cfg_pkg

// ### prot_if.sv
/*
 * Carrier between the loader and its protection gate.
 * Assumes the loader drives the protect state and request target.
 */
`timescale 1ns/1ps
`default_nettype none

interface prot_if (
   input wire logic clk,
   input wire logic rst_b
);
   logic                    prot_first;
   logic                    prot_second;
   cfg_pkg::pgm_target_type target;
   logic                    wr_ok;
   logic                    verify_ok;
   logic                    unsupported;

   modport gate (input clk, input rst_b, input prot_first, input prot_second,
                 input target, output wr_ok, output verify_ok, output unsupported);
   modport user (output prot_first, output prot_second, output target,
                 input wr_ok, input verify_ok, input unsupported);
endinterface : prot_if

`default_nettype wire

// ### prot_gate.sv
/*
 * Code-protection decision: which programming and verify requests
 * the present state of the two protect bits lets through.
 * Assumes protect bits read 1 while unprogrammed, 0 once programmed.
 */
`timescale 1ns/1ps
`default_nettype none

module prot_gate (
   prot_if.gate p
);

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire none_prog  = p.prot_first & p.prot_second;
   wire first_only = ~p.prot_first & p.prot_second;
   wire tgt_second = (p.target == cfg_pkg::TGT_PROT2);

   // Unsupported combination refuses everything: fail closed
   assign p.wr_ok       = none_prog | (first_only & tgt_second);
   assign p.verify_ok   = p.prot_second;
   assign p.unsupported = p.prot_first & ~p.prot_second;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_gate_locked;
      @(posedge p.clk) disable iff (!p.rst_b)
      (!p.prot_first && !p.prot_second) |-> (!p.wr_ok && !p.verify_ok);
   endproperty
   a_gate_locked: assert property (p_gate_locked)
      else $error("locked device let a request through");

   property p_gate_open;
      @(posedge p.clk) disable iff (!p.rst_b)
      (p.prot_first && p.prot_second) |-> (p.wr_ok && p.verify_ok);
   endproperty
   a_gate_open: assert property (p_gate_open)
      else $error("open device refused a request");

endmodule : prot_gate

`default_nettype wire

// ### config_fuse_and_security.sv
/*
 * Configuration loader and code-protection control. Captures the two
 * configuration bytes and the protect bits once after reset, serves
 * the first byte to external-data reads, and gates programmer requests.
 * Assumes the storage outputs are stable while reset is released and
 * that all inputs are synchronous to SYS_CLK.
 */
// What this block does
// - Capture configuration once after reset, then freeze
// - Hold two configuration bytes from non-volatile storage
// - External-data read at FD00h returns byte one
// - No protect bits: program and verify allowed
// - First protect bit only: refuse code programming
// - First protect bit only: second bit still programmable
// - Both protect bits: refuse verify and programming
`timescale 1ns/1ps
`default_nettype none

module config_fuse_and_security (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   // Non-volatile storage contents
   input  wire logic [7:0]  FUSE_BYTE_ONE,
   input  wire logic [7:0]  FUSE_BYTE_TWO,
   input  wire logic        FUSE_PROT_FIRST,
   input  wire logic        FUSE_PROT_SECOND,
   // External-data read port
   input  wire logic        XDATA_RD,
   input  wire logic [15:0] XDATA_ADDR,
   output logic             XDATA_RVALID,
   output logic [7:0]       XDATA_RDATA,
   // Programmer requests
   input  wire logic        PGM_WR_REQ,
   input  wire logic [1:0]  PGM_TARGET,
   input  wire logic        PGM_VERIFY_REQ,
   output logic             PGM_WR_GO,
   output logic             PGM_WR_REFUSED,
   output logic             PGM_VERIFY_GO,
   output logic             PGM_VERIFY_BLOCKED,
   // Configuration outputs
   output logic             CONFIG_READY,
   output logic [7:0]       CFG_BYTE_ONE,
   output logic [7:0]       CFG_BYTE_TWO,
   output logic             WATCHDOG_EN,
   output logic             PORT_RESET_HIGH,
   output logic [2:0]       OSC_MODE,
   output logic             OSC_RESERVED,
   output logic             PROT_FIRST,
   output logic             PROT_SECOND,
   output logic             PROT_UNSUPPORTED
);

   // ****************************************************************
   // State
   // ****************************************************************
   cfg_pkg::load_state_type state_q;
   cfg_pkg::load_state_type state_d;
   logic [7:0]              cfg_one_q;
   logic [7:0]              cfg_two_q;
   logic                    prot1_q;
   logic                    prot2_q;
   logic                    rvalid_q;
   logic [7:0]              rdata_q;
   logic                    wr_go_q;
   logic                    wr_ref_q;
   logic                    ver_go_q;
   logic                    ver_blk_q;
   logic                    wdt_q;
   logic                    prl_q;
   cfg_pkg::osc_mode_type   osc_q;
   logic                    osc_rsvd_q;
   logic                    unsup_q;
   logic                    ready_q;

   prot_if pif (.clk(SYS_CLK), .rst_b(RST_B));

   prot_gate u_gate (.p(pif.gate));

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire running   = (state_q == cfg_pkg::ST_RUN);
   wire loading   = (state_q == cfg_pkg::ST_LOAD);
   wire run_next  = (state_d == cfg_pkg::ST_RUN);
   wire cfg_hit   = (XDATA_ADDR == cfg_pkg::CFG_ONE_ADDR);
   wire wr_take   = PGM_WR_REQ & running;
   wire wr_pass   = wr_take & pif.wr_ok;
   wire ver_take  = PGM_VERIFY_REQ & running;
   wire set_prot1 = wr_pass & (pif.target == cfg_pkg::TGT_PROT1);
   wire set_prot2 = wr_pass & (pif.target == cfg_pkg::TGT_PROT2);
   wire [2:0] osc_field =
      cfg_one_q[cfg_pkg::OSC_SELECT_LSB +: cfg_pkg::OSC_SELECT_W];
   wire cfg_osc_rsvd = (cfg_pkg::osc_decode(osc_field) == cfg_pkg::MODE_RSVD);

   assign pif.prot_first  = prot1_q;
   assign pif.prot_second = prot2_q;
   assign pif.target      = cfg_pkg::pgm_target_type'(PGM_TARGET);

   // ****************************************************************
   // Load sequence
   // ****************************************************************
   // Storage is read on the second edge after release, never under reset itself
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         cfg_pkg::ST_IDLE: state_d = cfg_pkg::ST_LOAD;
         cfg_pkg::ST_LOAD: state_d = cfg_pkg::ST_RUN;
         cfg_pkg::ST_RUN:  state_d = cfg_pkg::ST_RUN;
         default:          state_d = cfg_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q   <= cfg_pkg::ST_IDLE;
         ready_q   <= 1'b0;
         cfg_one_q <= cfg_pkg::UNPROG_BYTE;
         cfg_two_q <= cfg_pkg::UNPROG_BYTE;
      end else begin
         state_q <= state_d;
         // Ready flag gets its own flop so the pin has no decode behind it
         ready_q <= run_next;
         if (loading) begin
            cfg_one_q <= FUSE_BYTE_ONE;
            cfg_two_q <= FUSE_BYTE_TWO;
         end
      end
   end

   // Protect bits also follow a granted programming of themselves
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         prot1_q <= cfg_pkg::UNPROG_BIT;
         prot2_q <= cfg_pkg::UNPROG_BIT;
      end else if (loading) begin
         prot1_q <= FUSE_PROT_FIRST;
         prot2_q <= FUSE_PROT_SECOND;
      end else begin
         if (set_prot1) prot1_q <= 1'b0;
         if (set_prot2) prot2_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Read port and programmer answers
   // ****************************************************************
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rvalid_q  <= 1'b0;
         rdata_q   <= cfg_pkg::UNMAPPED_DATA;
         wr_go_q   <= 1'b0;
         wr_ref_q  <= 1'b0;
         ver_go_q  <= 1'b0;
         ver_blk_q <= 1'b0;
      end else begin
         rvalid_q  <= XDATA_RD;
         rdata_q   <= (XDATA_RD & cfg_hit) ? cfg_one_q : cfg_pkg::UNMAPPED_DATA;
         wr_go_q   <= wr_pass;
         wr_ref_q  <= PGM_WR_REQ & ~wr_pass;
         ver_go_q  <= ver_take & pif.verify_ok;
         ver_blk_q <= PGM_VERIFY_REQ & ~(ver_take & pif.verify_ok);
      end
   end

   // ****************************************************************
   // Decoded configuration
   // ****************************************************************
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wdt_q      <= cfg_pkg::UNPROG_BIT;
         prl_q      <= cfg_pkg::UNPROG_BIT;
         osc_q      <= cfg_pkg::MODE_EXT;
         osc_rsvd_q <= 1'b0;
         unsup_q    <= 1'b0;
      end else begin
         wdt_q      <= cfg_one_q[cfg_pkg::WATCHDOG_FUSE_POS];
         prl_q      <= cfg_one_q[cfg_pkg::PORT_RESET_LEVEL_POS];
         osc_q      <= cfg_pkg::osc_decode(osc_field);
         osc_rsvd_q <= cfg_osc_rsvd;
         unsup_q    <= pif.unsupported;
      end
   end

   assign XDATA_RVALID       = rvalid_q;
   assign XDATA_RDATA        = rdata_q;
   assign PGM_WR_GO          = wr_go_q;
   assign PGM_WR_REFUSED     = wr_ref_q;
   assign PGM_VERIFY_GO      = ver_go_q;
   assign PGM_VERIFY_BLOCKED = ver_blk_q;
   assign CONFIG_READY       = ready_q;
   assign CFG_BYTE_ONE       = cfg_one_q;
   assign CFG_BYTE_TWO       = cfg_two_q;
   assign WATCHDOG_EN        = wdt_q;
   assign PORT_RESET_HIGH    = prl_q;
   assign OSC_MODE           = osc_q;
   assign OSC_RESERVED       = osc_rsvd_q;
   assign PROT_FIRST         = prot1_q;
   assign PROT_SECOND        = prot2_q;
   assign PROT_UNSUPPORTED   = unsup_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_cfg_frozen;
      @(posedge SYS_CLK) disable iff (!RST_B)
      running |=> ($stable(cfg_one_q) && $stable(cfg_two_q));
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen)
      else $error("configuration changed while running");

   property p_load_capture;
      @(posedge SYS_CLK) disable iff (!RST_B)
      loading |=> (cfg_two_q == $past(FUSE_BYTE_TWO)) && running;
   endproperty
   a_load_capture: assert property (p_load_capture)
      else $error("configuration byte two not captured");

   property p_cfg_read;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (XDATA_RD && cfg_hit) |=> XDATA_RVALID && (XDATA_RDATA == $past(cfg_one_q));
   endproperty
   a_cfg_read: assert property (p_cfg_read)
      else $error("byte one read returned wrong data");

   property p_wr_open;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (wr_take && prot1_q && prot2_q) |=> PGM_WR_GO && !PGM_WR_REFUSED;
   endproperty
   a_wr_open: assert property (p_wr_open)
      else $error("open device refused programming");

   property p_wr_first;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (wr_take && !prot1_q && prot2_q && PGM_TARGET != cfg_pkg::TGT_PROT2)
         |=> PGM_WR_REFUSED && !PGM_WR_GO;
   endproperty
   a_wr_first: assert property (p_wr_first)
      else $error("protected device accepted programming");

   property p_prot2_ok;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (wr_take && !prot1_q && prot2_q && PGM_TARGET == cfg_pkg::TGT_PROT2)
         |=> PGM_WR_GO && !PROT_SECOND ##1 PROT_SECOND == 1'b0;
   endproperty
   a_prot2_ok: assert property (p_prot2_ok)
      else $error("second protect bit not programmable");

   property p_locked;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (running && !prot1_q && !prot2_q && (PGM_VERIFY_REQ || PGM_WR_REQ))
         |=> !PGM_VERIFY_GO && !PGM_WR_GO;
   endproperty
   a_locked: assert property (p_locked)
      else $error("locked device answered a request");

   property p_osc;
      @(posedge SYS_CLK) disable iff (!RST_B)
      running ##1 running |-> OSC_MODE == cfg_pkg::osc_decode($past(osc_field));
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator mode wrong");

   property p_prl;
      @(posedge SYS_CLK) disable iff (!RST_B)
      running ##1 running |->
         PORT_RESET_HIGH == $past(cfg_one_q[cfg_pkg::PORT_RESET_LEVEL_POS]);
   endproperty
   a_prl: assert property (p_prl)
      else $error("port reset level wrong");

endmodule : config_fuse_and_security

`default_nettype wire

// ### cfg_programmer_model.sv
/*
 * Behavioural model of the outside programming system: holds the
 * non-volatile storage contents and issues program and verify requests.
 * Assumes the bench calls its tasks and that responses come one edge later.
 */
`timescale 1ns/1ps
`default_nettype none

module cfg_programmer_model (
   // Clock
   input  wire logic        clk,
   // Storage contents
   output logic [7:0]       fuse_one,
   output logic [7:0]       fuse_two,
   output logic             prot_one,
   output logic             prot_two,
   // Requests
   output logic             wr_req,
   output logic [1:0]       target,
   output logic             verify_req,
   // Answers
   input  wire logic        wr_go,
   input  wire logic        wr_refused,
   input  wire logic        verify_go,
   input  wire logic        verify_blocked
);
   initial begin
      fuse_one   = 8'hff;
      fuse_two   = 8'hff;
      prot_one   = 1'b1;
      prot_two   = 1'b1;
      wr_req     = 1'b0;
      target     = 2'h0;
      verify_req = 1'b0;
   end

   // ****************************************************************
   // Storage and requests
   // ****************************************************************
   // Raw load stands in for a damaged part; normal burns keep codes legal
   task automatic store(input logic [7:0] b1, input logic [7:0] b2,
                        input logic p1, input logic p2, input logic raw);
      if (!raw && (b1[2:0] inside {3'h4, 3'h5, 3'h6})) begin
         b1[2:0] = fuse_one[2:0];
      end
      if (!raw && p1 && !p2) begin
         p2 = 1'b1;
      end
      fuse_one = b1;
      fuse_two = b2;
      prot_one = p1;
      prot_two = p2;
   endtask : store

   task automatic prog_write(input logic [1:0] tgt, output logic go, output logic refused);
      @(posedge clk);
      #2;
      wr_req = 1'b1;
      target = tgt;
      @(posedge clk);
      #2;
      wr_req  = 1'b0;
      go      = wr_go;
      refused = wr_refused;
   endtask : prog_write

   task automatic verify(output logic go, output logic blocked);
      @(posedge clk);
      #2;
      verify_req = 1'b1;
      @(posedge clk);
      #2;
      verify_req = 1'b0;
      go         = verify_go;
      blocked    = verify_blocked;
   endtask : verify
endmodule : cfg_programmer_model

`default_nettype wire

// ### config_fuse_and_security_tb.sv
/*
 * Self-checking bench for the configuration and protection block.
 * Assumes the programmer model file is compiled before this one.
 */
`timescale 1ns/1ps
`default_nettype none

module config_fuse_and_security_tb;
   logic        SYS_CLK, RST_B, XDATA_RD, XDATA_RVALID, CONFIG_READY;
   logic [15:0] XDATA_ADDR;
   logic [7:0]  XDATA_RDATA, CFG_BYTE_ONE, CFG_BYTE_TWO, fuse_one, fuse_two, b1;
   logic        WATCHDOG_EN, PORT_RESET_HIGH, OSC_RESERVED, PROT_FIRST, PROT_SECOND;
   logic        PROT_UNSUPPORTED, prot_one, prot_two, wr_req, verify_req;
   logic        wr_go, wr_refused, verify_go, verify_blocked, go, no;
   logic [1:0]  target;
   logic [2:0]  OSC_MODE;
   int          errors, samples_checked;

   initial begin
      SYS_CLK = 1'b0;
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end

   cfg_programmer_model prog (.clk(SYS_CLK), .fuse_one(fuse_one), .fuse_two(fuse_two),
      .prot_one(prot_one), .prot_two(prot_two), .wr_req(wr_req), .target(target),
      .verify_req(verify_req), .wr_go(wr_go), .wr_refused(wr_refused),
      .verify_go(verify_go), .verify_blocked(verify_blocked));

   config_fuse_and_security uut (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
      .FUSE_BYTE_ONE(fuse_one), .FUSE_BYTE_TWO(fuse_two), .FUSE_PROT_FIRST(prot_one),
      .FUSE_PROT_SECOND(prot_two), .XDATA_RD(XDATA_RD), .XDATA_ADDR(XDATA_ADDR),
      .XDATA_RVALID(XDATA_RVALID), .XDATA_RDATA(XDATA_RDATA), .PGM_WR_REQ(wr_req),
      .PGM_TARGET(target), .PGM_VERIFY_REQ(verify_req), .PGM_WR_GO(wr_go),
      .PGM_WR_REFUSED(wr_refused), .PGM_VERIFY_GO(verify_go),
      .PGM_VERIFY_BLOCKED(verify_blocked), .CONFIG_READY(CONFIG_READY),
      .CFG_BYTE_ONE(CFG_BYTE_ONE), .CFG_BYTE_TWO(CFG_BYTE_TWO), .WATCHDOG_EN(WATCHDOG_EN),
      .PORT_RESET_HIGH(PORT_RESET_HIGH), .OSC_MODE(OSC_MODE), .OSC_RESERVED(OSC_RESERVED),
      .PROT_FIRST(PROT_FIRST), .PROT_SECOND(PROT_SECOND),
      .PROT_UNSUPPORTED(PROT_UNSUPPORTED));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict;
      if (errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   function automatic logic [2:0] exp_mode(input logic [2:0] code);
      case (code)
         3'h7:    return cfg_pkg::MODE_EXT;
         3'h3:    return cfg_pkg::MODE_RC;
         3'h2:    return cfg_pkg::MODE_LF;
         3'h1:    return cfg_pkg::MODE_MF;
         3'h0:    return cfg_pkg::MODE_HF;
         default: return cfg_pkg::MODE_RSVD;
      endcase
   endfunction : exp_mode

   // Fuses settle before release, so the load edge sees them stable
   task automatic do_reset(input logic [7:0] f1, input logic [7:0] f2,
                           input logic p1, input logic p2, input logic raw);
      @(posedge SYS_CLK);
      #2;
      RST_B = 1'b0;
      prog.store(f1, f2, p1, p2, raw);
      repeat (3) @(posedge SYS_CLK);
      #2;
      check("ready in reset", CONFIG_READY, 16'h0000);
      check("byte one in reset", CFG_BYTE_ONE, 16'h00ff);
      RST_B = 1'b1;
      repeat (4) @(posedge SYS_CLK);
      #2;
      check("ready", CONFIG_READY, 16'h0001);
   endtask : do_reset

   task automatic check_cfg(input logic [7:0] f1, input logic [7:0] f2);
      check("byte one", CFG_BYTE_ONE, f1);
      check("byte two", CFG_BYTE_TWO, f2);
      check("watchdog", WATCHDOG_EN, f1[7]);
      check("port level", PORT_RESET_HIGH, f1[5]);
      check("osc mode", OSC_MODE, exp_mode(f1[2:0]));
      check("osc reserved", OSC_RESERVED, f1[2:0] inside {3'h4, 3'h5, 3'h6});
   endtask : check_cfg

   task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
      @(posedge SYS_CLK);
      #2;
      XDATA_RD   = 1'b1;
      XDATA_ADDR = addr;
      @(posedge SYS_CLK);
      #2;
      XDATA_RD = 1'b0;
      check("read valid", XDATA_RVALID, 16'h0001);
      check("read data", XDATA_RDATA, exp);
   endtask : rd

   task automatic pg(input logic [1:0] tgt, input logic exp_go);
      prog.prog_write(tgt, go, no);
      check("program go", go, exp_go);
      check("program refused", no, !exp_go);
   endtask : pg

   task automatic vf(input logic exp_go);
      prog.verify(go, no);
      check("verify go", go, exp_go);
      check("verify blocked", no, !exp_go);
   endtask : vf

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      errors = 0;
      samples_checked = 0;
      RST_B = 1'b0;
      XDATA_RD = 1'b0;
      XDATA_ADDR = 16'h0000;
      for (int c = 0; c < 8; c++) begin
         b1 = {c[0], 1'b1, c[1], 2'b11, c[2:0]};
         do_reset(b1, 8'h5a ^ c[7:0], 1'b1, 1'b1, 1'b1);
         check_cfg(b1, 8'h5a ^ c[7:0]);
      end
      // Read back, then storage changes must not leak through
      do_reset(8'h23, 8'hc6, 1'b1, 1'b1, 1'b0);
      rd(cfg_pkg::CFG_ONE_ADDR, 8'h23);
      rd(16'hfd01, cfg_pkg::UNMAPPED_DATA);
      prog.store(8'h9b, 8'h11, 1'b0, 1'b0, 1'b0);
      rd(cfg_pkg::CFG_ONE_ADDR, 8'h23);
      check_cfg(8'h23, 8'hc6);
      check("first bit held", PROT_FIRST, 16'h0001);
      check("supported", PROT_UNSUPPORTED, 16'h0000);
      // Protection walk from the open state
      vf(1'b1);
      pg(2'h0, 1'b1);
      pg(2'h2, 1'b1);
      check("first bit", PROT_FIRST, 16'h0000);
      pg(2'h0, 1'b0);
      pg(2'h1, 1'b0);
      vf(1'b1);
      pg(2'h3, 1'b1);
      check("second bit", PROT_SECOND, 16'h0000);
      pg(2'h3, 1'b0);
      pg(2'h0, 1'b0);
      vf(1'b0);
      // First bit already stored as programmed
      do_reset(8'hff, 8'hff, 1'b0, 1'b1, 1'b0);
      check("stored first", PROT_FIRST, 16'h0000);
      pg(2'h1, 1'b0);
      pg(2'h2, 1'b0);
      pg(2'h3, 1'b1);
      vf(1'b0);
      // Damaged part with only the second bit programmed fails closed
      do_reset(8'hff, 8'hff, 1'b1, 1'b0, 1'b1);
      check("unsupported", PROT_UNSUPPORTED, 16'h0001);
      pg(2'h3, 1'b0);
      vf(1'b0);
      give_verdict();
   end

   // Whole run is well under a few thousand cycles
   initial begin
      #2000000;
      errors++;
      give_verdict();
   end
endmodule : config_fuse_and_security_tb

`default_nettype wire
